// [cfg_header_pkg.sv]
// Constants and carrier types for the configuration header window
package cfg_header_pkg;

   // ------------------------------------------------------------
   // Configuration offsets (byte offsets, dword aligned access)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_HOLD_LINE = 8'h0c;
   localparam logic [7:0] OFS_LAYOUT_SELFTEST = 8'h0e;
   localparam logic [7:0] OFS_HOST_CTRL_BASE = 8'h10;
   localparam logic [7:0] OFS_VENDOR_EXT_BASE = 8'h14;
   localparam logic [5:0] DW_HOLD_LINE = 6'h03;
   localparam logic [5:0] DW_HOST_CTRL_BASE = 6'h04;
   localparam logic [5:0] DW_VENDOR_EXT_BASE = 6'h05;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int LINE_BURST_LSB = 0;
   localparam int HOLD_LIMIT_LSB = 8;
   localparam int LAYOUT_LSB = 16;
   localparam int SELFTEST_LSB = 24;
   localparam int HOST_CTRL_BASE_LSB = 11;
   localparam int VENDOR_EXT_BASE_LSB = 14;

   // ------------------------------------------------------------
   // Reset and fixed values
   // ------------------------------------------------------------
   localparam logic [7:0] LINE_BURST_RESET = 8'h00;
   localparam logic [7:0] HOLD_LIMIT_RESET = 8'h00;
   localparam logic [7:0] SELFTEST_VALUE = 8'h00;
   localparam logic [7:0] LAYOUT_VALUE = 8'h00;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] HOST_CTRL_WR_MASK = 32'hffff_f800;
   localparam logic [31:0] VENDOR_EXT_WR_MASK = 32'hffff_c000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // ------------------------------------------------------------
   // Bus commands that use the line burst length
   // ------------------------------------------------------------
   localparam logic [3:0] CMD_MEM_READ_MULTIPLE = 4'hc;
   localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
   localparam logic [3:0] CMD_MEM_WRITE_INVALIDATE = 4'hf;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } cfg_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } cfg_resp_s;

   typedef enum logic [2:0] {
      INIT_IDLE = 3'b001,
      INIT_ACTIVE = 3'b010,
      INIT_EXPIRED = 3'b100
   } init_state_e;

endpackage

// [initiator_hold_timer.sv]
// Initiator hold counter that flags when the programmed limit is reached
`timescale 1ns/10ps

module initiator_hold_timer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Control
   input wire logic start_in,
   input wire logic run_in,
   input wire logic [WIDTH-1:0] limit_in,
   // Status
   output logic expired_out
);

   initial begin
      if (WIDTH < 1 || WIDTH > 16) begin
         $error("initiator_hold_timer: WIDTH out of range");
      end
   end

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic expired_d;
   wire at_limit = (count_q == limit_in);

   // Restart from zero on every bus start; hold at limit
   assign count_d = start_in ? '0 :
                    (run_in && !at_limit) ? count_q + 1'b1 : count_q;
   assign expired_d = start_in ? 1'b0 : (run_in && at_limit);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count_q <= '0;
         expired_out <= 1'b0;
      end else begin
         count_q <= count_d;
         expired_out <= expired_d;
      end
   end

endmodule

// [cfg_header_window.sv]
// Configuration header window: hold limit, line burst, header fields, two window bases
`timescale 1ns/10ps

module cfg_header_window #(
   parameter int HOLD_WIDTH = 8,
   parameter int ADDR_WIDTH = 32
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Configuration access
   input wire cfg_header_pkg::cfg_req_s cfg_req_in,
   output cfg_header_pkg::cfg_resp_s cfg_resp_out,
   // Initiator bus activity
   input wire logic frame_start_in,
   input wire logic [3:0] bus_cmd_in,
   input wire logic txn_done_in,
   input wire logic gnt_n_in,
   output logic initiator_stop_out,
   output logic hold_expired_out,
   output logic [7:0] burst_limit_out,
   // Target memory decode
   input wire logic mem_space_en_in,
   input wire logic mem_addr_valid_in,
   input wire logic [ADDR_WIDTH-1:0] mem_addr_in,
   output logic host_ctrl_hit_out,
   output logic vendor_ext_hit_out,
   // Programmed values for the rest of the function
   output logic [7:0] line_burst_length_out,
   output logic [7:0] hold_limit_out,
   output logic [31:0] host_ctrl_base_out,
   output logic [31:0] vendor_ext_base_out
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   initial begin
      if (HOLD_WIDTH != 8) begin
         $error("cfg_header_window: hold limit field is 8 bits");
      end
      if (ADDR_WIDTH != 32) begin
         $error("cfg_header_window: windows decode 32-bit addresses");
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [31:0] merge_write(input logic [31:0] old_val, input logic [31:0] new_val,
                                               input logic [3:0] be, input logic [31:0] wr_mask);
      logic [31:0] m;
      m = be_mask(be) & wr_mask;
      merge_write = (old_val & ~m) | (new_val & m);
   endfunction

   function automatic logic window_hit(input logic [31:0] addr, input logic [31:0] base,
                                       input logic [31:0] mask);
      window_hit = ((addr & mask) == (base & mask));
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0] line_burst_length_q;
   logic [7:0] line_burst_length_d;
   logic [7:0] hold_limit_q;
   logic [7:0] hold_limit_d;
   logic [31:0] host_ctrl_base_q;
   logic [31:0] host_ctrl_base_d;
   logic [31:0] vendor_ext_base_q;
   logic [31:0] vendor_ext_base_d;

   // ------------------------------------------------------------
   // Configuration decode
   // ------------------------------------------------------------
   wire [5:0] cfg_dword = cfg_req_in.addr[7:2];
   wire cfg_wr = cfg_req_in.wr;
   wire cfg_rd = cfg_req_in.rd;
   wire sel_hold_line = (cfg_dword == cfg_header_pkg::DW_HOLD_LINE);
   wire sel_host_ctrl = (cfg_dword == cfg_header_pkg::DW_HOST_CTRL_BASE);
   wire sel_vendor_ext = (cfg_dword == cfg_header_pkg::DW_VENDOR_EXT_BASE);
   wire wr_hold_line = cfg_wr && sel_hold_line;
   wire wr_host_ctrl = cfg_wr && sel_host_ctrl;
   wire wr_vendor_ext = cfg_wr && sel_vendor_ext;

   // Upper half of the 0ch dword (layout and self-test) takes no write data
   wire [31:0] hold_line_wr_mask = 32'h0000_ffff;
   wire [31:0] hold_line_cur = {16'h0000, hold_limit_q, line_burst_length_q};
   wire [31:0] hold_line_new = merge_write(hold_line_cur, cfg_req_in.wdata, cfg_req_in.be,
                                           hold_line_wr_mask);

   // ------------------------------------------------------------
   // Next register values
   // ------------------------------------------------------------
   assign line_burst_length_d = wr_hold_line ?
                                hold_line_new[cfg_header_pkg::LINE_BURST_LSB +: 8] :
                                line_burst_length_q;
   assign hold_limit_d = wr_hold_line ?
                         hold_line_new[cfg_header_pkg::HOLD_LIMIT_LSB +: 8] :
                         hold_limit_q;
   // Read-only low bits never take write data
   assign host_ctrl_base_d = wr_host_ctrl ?
                             merge_write(host_ctrl_base_q, cfg_req_in.wdata, cfg_req_in.be,
                                         cfg_header_pkg::HOST_CTRL_WR_MASK) :
                             host_ctrl_base_q;
   assign vendor_ext_base_d = wr_vendor_ext ?
                              merge_write(vendor_ext_base_q, cfg_req_in.wdata, cfg_req_in.be,
                                          cfg_header_pkg::VENDOR_EXT_WR_MASK) :
                              vendor_ext_base_q;

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   wire [31:0] rd_hold_line = {cfg_header_pkg::SELFTEST_VALUE,
                               cfg_header_pkg::LAYOUT_VALUE,
                               hold_limit_q,
                               line_burst_length_q};
   // Stored value already has read-only bits at zero
   wire [31:0] rd_host_ctrl = host_ctrl_base_q & cfg_header_pkg::HOST_CTRL_WR_MASK;
   wire [31:0] rd_vendor_ext = vendor_ext_base_q & cfg_header_pkg::VENDOR_EXT_WR_MASK;
   wire [31:0] rd_data = sel_hold_line ? rd_hold_line :
                         sel_host_ctrl ? rd_host_ctrl :
                         sel_vendor_ext ? rd_vendor_ext :
                         cfg_header_pkg::UNMAPPED_READ;
   wire [31:0] rd_data_d = cfg_rd ? (rd_data & be_mask(cfg_req_in.be)) : 32'h0000_0000;
   wire cfg_ack_d = cfg_rd || cfg_wr;

   // ------------------------------------------------------------
   // Register update
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         line_burst_length_q <= cfg_header_pkg::LINE_BURST_RESET;
      end else begin
         line_burst_length_q <= line_burst_length_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         hold_limit_q <= cfg_header_pkg::HOLD_LIMIT_RESET;
      end else begin
         hold_limit_q <= hold_limit_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         host_ctrl_base_q <= cfg_header_pkg::BASE_RESET;
      end else begin
         host_ctrl_base_q <= host_ctrl_base_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         vendor_ext_base_q <= cfg_header_pkg::BASE_RESET;
      end else begin
         vendor_ext_base_q <= vendor_ext_base_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cfg_resp_out <= '0;
      end else begin
         cfg_resp_out.ack <= cfg_ack_d;
         cfg_resp_out.rdata <= rd_data_d;
      end
   end

   // ------------------------------------------------------------
   // Programmed values seen by the rest of the function
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         line_burst_length_out <= cfg_header_pkg::LINE_BURST_RESET;
      end else begin
         line_burst_length_out <= line_burst_length_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         hold_limit_out <= cfg_header_pkg::HOLD_LIMIT_RESET;
      end else begin
         hold_limit_out <= hold_limit_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         host_ctrl_base_out <= cfg_header_pkg::BASE_RESET;
      end else begin
         host_ctrl_base_out <= host_ctrl_base_d & cfg_header_pkg::HOST_CTRL_WR_MASK;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         vendor_ext_base_out <= cfg_header_pkg::BASE_RESET;
      end else begin
         vendor_ext_base_out <= vendor_ext_base_d & cfg_header_pkg::VENDOR_EXT_WR_MASK;
      end
   end

   // ------------------------------------------------------------
   // Initiator hold counter
   // ------------------------------------------------------------
   cfg_header_pkg::init_state_e state_q;
   cfg_header_pkg::init_state_e state_d;
   logic timer_expired;
   logic stop_d;

   wire in_txn = (state_q != cfg_header_pkg::INIT_IDLE);

   initiator_hold_timer #(
      .WIDTH(HOLD_WIDTH)
   ) initiator_hold_timer_inst (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .start_in(frame_start_in),
      .run_in(in_txn && !txn_done_in),
      .limit_in(hold_limit_q),
      .expired_out(timer_expired)
   );

   always_comb begin
      state_d = state_q;
      stop_d = 1'b0;
      case (state_q)
         cfg_header_pkg::INIT_IDLE: begin
            if (frame_start_in) begin
               state_d = cfg_header_pkg::INIT_ACTIVE;
            end
         end
         cfg_header_pkg::INIT_ACTIVE: begin
            if (txn_done_in) begin
               state_d = cfg_header_pkg::INIT_IDLE;
            end else if (timer_expired) begin
               state_d = cfg_header_pkg::INIT_EXPIRED;
            end
         end
         cfg_header_pkg::INIT_EXPIRED: begin
            if (txn_done_in) begin
               state_d = cfg_header_pkg::INIT_IDLE;
            end else if (gnt_n_in) begin
               stop_d = 1'b1;
               state_d = cfg_header_pkg::INIT_IDLE;
            end
         end
         default: begin
            state_d = cfg_header_pkg::INIT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_q <= cfg_header_pkg::INIT_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         initiator_stop_out <= 1'b0;
      end else begin
         initiator_stop_out <= stop_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         hold_expired_out <= 1'b0;
      end else begin
         hold_expired_out <= (state_d == cfg_header_pkg::INIT_EXPIRED);
      end
   end

   // ------------------------------------------------------------
   // Line burst length per command
   // ------------------------------------------------------------
   wire line_cmd = (bus_cmd_in == cfg_header_pkg::CMD_MEM_READ_MULTIPLE) ||
                   (bus_cmd_in == cfg_header_pkg::CMD_MEM_READ_LINE) ||
                   (bus_cmd_in == cfg_header_pkg::CMD_MEM_WRITE_INVALIDATE);
   wire [7:0] burst_limit_d = frame_start_in ? (line_cmd ? line_burst_length_q : 8'h00) :
                              burst_limit_out;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         burst_limit_out <= 8'h00;
      end else begin
         burst_limit_out <= burst_limit_d;
      end
   end

   // ------------------------------------------------------------
   // Window decode for target memory accesses
   // ------------------------------------------------------------
   wire host_hit_d = mem_space_en_in && mem_addr_valid_in &&
                     window_hit(mem_addr_in, host_ctrl_base_q, cfg_header_pkg::HOST_CTRL_WR_MASK);
   wire vendor_hit_d = mem_space_en_in && mem_addr_valid_in &&
                       window_hit(mem_addr_in, vendor_ext_base_q, cfg_header_pkg::VENDOR_EXT_WR_MASK);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         host_ctrl_hit_out <= 1'b0;
      end else begin
         host_ctrl_hit_out <= host_hit_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         vendor_ext_hit_out <= 1'b0;
      end else begin
         vendor_ext_hit_out <= vendor_hit_d;
      end
   end

endmodule

// [cfg_header_window_props.sv]
// Assertion checker for the configuration header window
`timescale 1ns/10ps

module cfg_header_window_props #(
   parameter int HOLD_WIDTH = 8,
   parameter int ADDR_WIDTH = 32
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Configuration access
   input wire cfg_header_pkg::cfg_req_s cfg_req_in,
   input wire cfg_header_pkg::cfg_resp_s cfg_resp_out,
   // Initiator bus activity
   input wire logic frame_start_in,
   input wire logic [3:0] bus_cmd_in,
   input wire logic txn_done_in,
   input wire logic gnt_n_in,
   input wire logic initiator_stop_out,
   input wire logic hold_expired_out,
   input wire logic [7:0] burst_limit_out,
   // Target memory decode
   input wire logic mem_space_en_in,
   input wire logic mem_addr_valid_in,
   input wire logic [ADDR_WIDTH-1:0] mem_addr_in,
   input wire logic host_ctrl_hit_out,
   input wire logic vendor_ext_hit_out,
   // Programmed values
   input wire logic [7:0] line_burst_length_out,
   input wire logic [7:0] hold_limit_out,
   input wire logic [31:0] host_ctrl_base_out,
   input wire logic [31:0] vendor_ext_base_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   wire [5:0] req_dw = cfg_req_in.addr[7:2];
   wire rd_hold = cfg_req_in.rd && req_dw == cfg_header_pkg::DW_HOLD_LINE;
   wire rd_host = cfg_req_in.rd && req_dw == cfg_header_pkg::DW_HOST_CTRL_BASE;
   wire rd_vend = cfg_req_in.rd && req_dw == cfg_header_pkg::DW_VENDOR_EXT_BASE;
   wire wr_full = cfg_req_in.wr && cfg_req_in.be == 4'hf;
   wire wr_host = wr_full && req_dw == cfg_header_pkg::DW_HOST_CTRL_BASE;
   wire wr_vend = wr_full && req_dw == cfg_header_pkg::DW_VENDOR_EXT_BASE;
   wire line_cmd = bus_cmd_in == cfg_header_pkg::CMD_MEM_READ_MULTIPLE
      || bus_cmd_in == cfg_header_pkg::CMD_MEM_READ_LINE || bus_cmd_in == cfg_header_pkg::CMD_MEM_WRITE_INVALIDATE;

   // Cycles since the last transaction start, saturating
   logic [8:0] since_q;
   always_ff @(posedge clk_in) begin
      since_q <= reset_in ? 9'h000 : frame_start_in ? 9'h001 : since_q + {8'h00, since_q != 9'h1ff};
   end

   property p_header_fixed;
      rd_hold |=> cfg_resp_out.rdata[31:16] == 16'h0000;
   endproperty
   a_header_fixed: assert property (p_header_fixed) else $error("layout or self-test field not zero");
   property p_host_ro;
      rd_host |=> cfg_resp_out.rdata[10:0] == 11'h000;
   endproperty
   a_host_ro: assert property (p_host_ro) else $error("host window low bits not zero");
   property p_vend_ro;
      rd_vend |=> cfg_resp_out.rdata[13:0] == 14'h0000;
   endproperty
   a_vend_ro: assert property (p_vend_ro) else $error("vendor window low bits not zero");
   property p_host_write;
      wr_host |=> host_ctrl_base_out == ($past(cfg_req_in.wdata) & cfg_header_pkg::HOST_CTRL_WR_MASK);
   endproperty
   a_host_write: assert property (p_host_write) else $error("host window base wrong after write");
   property p_vend_write;
      wr_vend |=> vendor_ext_base_out == ($past(cfg_req_in.wdata) & cfg_header_pkg::VENDOR_EXT_WR_MASK);
   endproperty
   a_vend_write: assert property (p_vend_write) else $error("vendor window base wrong after write");
   property p_reset_bases;
      $fell(reset_in) |-> host_ctrl_base_out == 32'h0000_0000 && vendor_ext_base_out == 32'h0000_0000;
   endproperty
   a_reset_bases: assert property (p_reset_bases) else $error("window base not zero after reset");
   property p_burst;
      frame_start_in |=> burst_limit_out == ($past(line_cmd) ? $past(line_burst_length_out) : 8'h00);
   endproperty
   a_burst: assert property (p_burst) else $error("burst limit wrong for command");
   property p_hold_count;
      $rose(hold_expired_out) |-> since_q == {1'b0, hold_limit_out} + 9'h003;
   endproperty
   a_hold_count: assert property (p_hold_count) else $error("hold expiry at wrong cycle");
   property p_hold_stop;
      hold_expired_out && gnt_n_in && !txn_done_in |=> initiator_stop_out && !hold_expired_out;
   endproperty
   a_hold_stop: assert property (p_hold_stop) else $error("no stop after grant removal");
endmodule

bind cfg_header_window cfg_header_window_props #(.HOLD_WIDTH(HOLD_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) props_inst (
   .clk_in(clk_in), .reset_in(reset_in), .cfg_req_in(cfg_req_in), .cfg_resp_out(cfg_resp_out),
   .frame_start_in(frame_start_in), .bus_cmd_in(bus_cmd_in), .txn_done_in(txn_done_in), .gnt_n_in(gnt_n_in),
   .initiator_stop_out(initiator_stop_out), .hold_expired_out(hold_expired_out), .burst_limit_out(burst_limit_out),
   .mem_space_en_in(mem_space_en_in), .mem_addr_valid_in(mem_addr_valid_in), .mem_addr_in(mem_addr_in),
   .host_ctrl_hit_out(host_ctrl_hit_out), .vendor_ext_hit_out(vendor_ext_hit_out),
   .line_burst_length_out(line_burst_length_out), .hold_limit_out(hold_limit_out),
   .host_ctrl_base_out(host_ctrl_base_out), .vendor_ext_base_out(vendor_ext_base_out));

// [arbiter_model.sv]
// Bus arbiter model that withdraws the grant from an initiator past its hold limit
`timescale 1ns/10ps

module arbiter_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Initiator status and grant delay
   input wire logic expired_in,
   input wire logic stop_in,
   input wire logic [3:0] delay_in,
   // Grant, active low
   output logic gnt_n_out
);
   logic [3:0] wait_q;
   always_ff @(posedge clk_in) begin
      if (reset_in || stop_in || !expired_in) begin
         wait_q <= 4'h0;
         gnt_n_out <= 1'b0;
      end else if (wait_q == delay_in) begin
         gnt_n_out <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

// [pci_config_header_window_bench.sv]
// Self-checking testbench for the configuration header window
`timescale 1ns/10ps

module pci_config_header_window_bench;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   cfg_header_pkg::cfg_req_s req = '0;
   cfg_header_pkg::cfg_resp_s resp;
   logic frame = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic done = 1'b0;
   logic mem_en = 1'b0;
   logic mem_valid = 1'b0;
   logic [31:0] mem_addr = 32'h0;
   logic [3:0] delay = 4'h0;
   logic gnt_n, stop, expired, host_hit, vend_hit, seen;
   logic [7:0] burst;
   logic [3:0] cmds [5] = '{4'hc, 4'he, 4'hf, 4'h7, 4'hd};
   int mismatches = 0;
   int compares = 0;

   always #20 clk_in = ~clk_in;

   cfg_header_window #(.HOLD_WIDTH(8), .ADDR_WIDTH(32)) cfg_header_window_inst (
      .clk_in(clk_in), .reset_in(reset_in), .cfg_req_in(req), .cfg_resp_out(resp),
      .frame_start_in(frame), .bus_cmd_in(cmd), .txn_done_in(done), .gnt_n_in(gnt_n),
      .initiator_stop_out(stop), .hold_expired_out(expired), .burst_limit_out(burst),
      .mem_space_en_in(mem_en), .mem_addr_valid_in(mem_valid), .mem_addr_in(mem_addr),
      .host_ctrl_hit_out(host_hit), .vendor_ext_hit_out(vend_hit), .line_burst_length_out(),
      .hold_limit_out(), .host_ctrl_base_out(), .vendor_ext_base_out());

   arbiter_model arbiter_model_inst (.clk_in(clk_in), .reset_in(reset_in), .expired_in(expired),
      .stop_in(stop), .delay_in(delay), .gnt_n_out(gnt_n));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One configuration cycle; the answer stands one cycle after the request edge
   task automatic access(input logic rd, input logic wr, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] wd, input logic [31:0] exp);
      @(posedge clk_in);
      req <= {rd, wr, a, be, wd};
      @(posedge clk_in);
      req <= '0;
      #1;
      check({31'h0, resp.ack}, 32'h1);
      if (rd) check(resp.rdata, exp);
   endtask

   task automatic decode(input logic en, input logic [31:0] a, input logic [1:0] exp);
      @(posedge clk_in);
      mem_en <= en;
      mem_addr <= a;
      mem_valid <= 1'b1;
      @(posedge clk_in);
      mem_valid <= 1'b0;
      #1;
      check({30'h0, host_hit, vend_hit}, {30'h0, exp});
   endtask

   task automatic start_frame(input logic [3:0] c);
      @(posedge clk_in);
      frame <= 1'b1;
      cmd <= c;
      @(posedge clk_in);
      frame <= 1'b0;
   endtask

   task automatic end_frame();
      @(posedge clk_in);
      done <= 1'b1;
      @(posedge clk_in);
      done <= 1'b0;
   endtask

   // Run until the hold limit expires, then until the grant loss stops the initiator
   task automatic hold_run(input int lim);
      int n;
      int m;
      n = 0;
      m = 0;
      start_frame(4'h7);
      while (expired !== 1'b1 && n < 40) begin
         @(posedge clk_in);
         n++;
         #1;
      end
      check(n, lim + 2);
      while (stop !== 1'b1 && m < 40) begin
         @(posedge clk_in);
         m++;
         #1;
      end
      check({30'h0, stop, expired}, 32'h2);
   endtask

   initial begin
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      access(1'b1, 1'b0, 8'h10, 4'hf, 32'h0, 32'h0000_0000);
      access(1'b1, 1'b0, 8'h14, 4'hf, 32'h0, 32'h0000_0000);
      access(1'b1, 1'b0, 8'h0c, 4'hf, 32'h0, 32'h0000_0000);
      access(1'b0, 1'b1, 8'h10, 4'hf, 32'hffff_ffff, 32'h0);
      access(1'b1, 1'b0, 8'h10, 4'hf, 32'h0, 32'hffff_f800);
      access(1'b0, 1'b1, 8'h14, 4'hf, 32'hffff_ffff, 32'h0);
      access(1'b1, 1'b0, 8'h14, 4'hf, 32'h0, 32'hffff_c000);
      access(1'b0, 1'b1, 8'h10, 4'h2, 32'h0, 32'h0);
      access(1'b1, 1'b0, 8'h10, 4'hf, 32'h0, 32'hffff_0000);
      access(1'b0, 1'b1, 8'h0c, 4'hf, 32'hffff_ffff, 32'h0);
      access(1'b1, 1'b0, 8'h0c, 4'hf, 32'h0, 32'h0000_ffff);
      // Unmapped offset: write dropped, read zero
      access(1'b0, 1'b1, 8'h18, 4'hf, 32'hffff_ffff, 32'h0);
      access(1'b1, 1'b0, 8'h18, 4'hf, 32'h0, 32'h0000_0000);
      access(1'b0, 1'b1, 8'h10, 4'hf, 32'h1234_57ff, 32'h0);
      access(1'b1, 1'b1, 8'h14, 4'hf, 32'h8000_ffff, 32'hffff_c000);
      access(1'b1, 1'b0, 8'h10, 4'hf, 32'h0, 32'h1234_5000);
      access(1'b1, 1'b0, 8'h14, 4'hf, 32'h0, 32'h8000_c000);
      decode(1'b1, 32'h1234_57fc, 2'b10);
      decode(1'b1, 32'h1234_5800, 2'b00);
      decode(1'b1, 32'h8000_c000, 2'b01);
      decode(1'b1, 32'h8000_bffc, 2'b00);
      decode(1'b0, 32'h1234_5000, 2'b00);
      access(1'b0, 1'b1, 8'h0c, 4'h3, 32'h0000_0210, 32'h0);
      access(1'b1, 1'b0, 8'h0c, 4'hf, 32'h0, 32'h0000_0210);
      for (int i = 0; i < 5; i++) begin
         start_frame(cmds[i]);
         #1;
         check({24'h0, burst}, (cmds[i] inside {4'hc, 4'he, 4'hf}) ? 32'h10 : 32'h0);
         end_frame();
      end
      hold_run(2);
      delay <= 4'h5;
      hold_run(2);
      access(1'b0, 1'b1, 8'h0c, 4'h2, 32'h0000_0500, 32'h0);
      hold_run(5);
      // Transaction that ends before its limit is never stopped
      start_frame(4'h7);
      end_frame();
      seen = 1'b0;
      repeat (12) begin
         @(posedge clk_in);
         #1;
         seen = seen | stop | expired;
      end
      check({31'h0, seen}, 32'h0);
      // Reset while idle clears both programmed window bases and the 0ch dword
      @(posedge clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      access(1'b1, 1'b0, 8'h10, 4'hf, 32'h0, 32'h0000_0000);
      access(1'b1, 1'b0, 8'h14, 4'hf, 32'h0, 32'h0000_0000);
      access(1'b1, 1'b0, 8'h0c, 4'hf, 32'h0, 32'h0000_0000);
      tally_and_finish();
   end

   initial begin
      repeat (4000) @(posedge clk_in);
      mismatches++;
      tally_and_finish();
   end
endmodule
